// ### phrp_pkg.sv
// Constants and types for the parallel host register port controller
package phrp_pkg;
    localparam int T_CLK_NS = 40;
    localparam int T_STROBE_ACT_NS = 40;
    localparam int T_STROBE_INACT_NS = 40;
    localparam int T_WR_SPACE_NS = 120;
    localparam int T_READBACK_NS = 120;
    localparam int T_RDY_MAX_NS = 90;
    localparam int SYNC_STAGES = 2;

    localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_ACT_NS + T_CLK_NS - 1) / T_CLK_NS);
    localparam logic [3:0] GAP_CYC = 4'((T_STROBE_INACT_NS + T_CLK_NS - 1) / T_CLK_NS);
    localparam logic [3:0] WR_GAP_CYC = 4'(((T_WR_SPACE_NS > T_READBACK_NS ? T_WR_SPACE_NS : T_READBACK_NS)
                                          + T_CLK_NS - 1) / T_CLK_NS);
    localparam logic [3:0] RDY_MIN_CYC = 4'(STROBE_CYC + SYNC_STAGES);
    localparam logic [3:0] RDY_TIMEOUT_CYC = 4'(T_RDY_MAX_NS / T_CLK_NS + 2 * SYNC_STAGES);

    localparam logic [7:0] UNLOCK_VAL = 8'h95;
    localparam logic [6:0] WP_REG_ADDR = 7'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_LATCH,
        ST_STROBE,
        ST_RELEASE,
        ST_GAP
    } phrp_state_t;

    typedef struct packed {
        logic write;
        logic protect;
        logic [6:0] addr;
        logic [7:0] wdata;
    } phrp_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic rd_strobe_n;
        logic wr_rw;
        logic ale;
        logic [7:0] ad_o;
        logic ad_oe;
        logic [6:0] addr;
    } phrp_pins_t;
endpackage

// ### phrp_timer.sv
// Loadable down counter for strobe and gap timing
`timescale 1ns/100ps
module phrp_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [3:0] count,
    output logic [3:0] remaining,
    output logic done
);
    always_ff @(posedge clk) begin
        if (srst) begin
            remaining <= 4'h0;
        end else if (load) begin
            remaining <= count;
        end else if (remaining != 4'h0) begin
            remaining <= remaining - 4'h1;
        end
    end

    assign done = (remaining == 4'h0);
endmodule // phrp_timer

// ### phrp_host.sv
// Host controller driving the parallel register port of the device
`timescale 1ns/100ps
module phrp_host
    import phrp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cfg_bus_style,
    input wire logic cfg_addr_mux,
    input wire logic cmd_valid,
    input wire phrp_cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_timeout,
    output logic bus_style_select,
    output logic address_mux_select,
    output phrp_pins_t pins,
    input wire logic [7:0] ad_i,
    input wire logic rdy_i
);
    phrp_state_t state;
    phrp_state_t next_state;
    phrp_cmd_t cur;
    phrp_cmd_t next_cur;
    phrp_pins_t next_pins;
    logic unlock_phase;
    logic next_unlock;
    logic [7:0] ad_s1;
    logic [7:0] ad_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic [3:0] remaining;
    logic t_done;

    // Pins arrive from another chip, so both pass two flops
    always_ff @(posedge clk) begin
        if (srst) begin
            ad_s1 <= 8'h00;
            ad_s2 <= 8'h00;
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
        end else begin
            ad_s1 <= ad_i;
            ad_s2 <= ad_s1;
            rdy_s1 <= rdy_i;
            rdy_s2 <= rdy_s1;
        end
    end

    wire fire = (state == ST_IDLE) && cmd_valid && cmd_ready;
    wire next_style = fire ? cfg_bus_style : bus_style_select;
    wire next_sep_addr = fire ? cfg_addr_mux : address_mux_select;
    // Ready seen too early may be a stale level from the previous access
    wire rdy_ok = rdy_s2 && (remaining <= RDY_TIMEOUT_CYC - RDY_MIN_CYC);
    wire strobe_end = (state == ST_STROBE) && (rdy_ok || t_done);
    wire enter_strobe = (next_state == ST_STROBE) && (state != ST_STROBE);
    wire enter_release = (next_state == ST_RELEASE);

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_unlock = unlock_phase;
        unique case (state)
            ST_IDLE: begin
                if (fire) begin
                    next_cur = cmd;
                    next_unlock = cmd.write && cmd.protect;
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                next_state = address_mux_select ? ST_STROBE : ST_LATCH;
            end
            ST_LATCH: begin
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (strobe_end) begin
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                next_state = ST_GAP;
            end
            ST_GAP: begin
                if (t_done) begin
                    next_state = unlock_phase ? ST_ADDR : ST_IDLE;
                    next_unlock = 1'b0;
                end
            end
        endcase
    end

    // Selection of what the current bus cycle carries
    wire op_write = next_unlock || next_cur.write;
    wire [6:0] op_addr = next_unlock ? WP_REG_ADDR : next_cur.addr;
    wire [7:0] op_data = next_unlock ? UNLOCK_VAL : next_cur.wdata;
    wire s_active = (next_state == ST_STROBE);
    wire s_addr_phase = (next_state == ST_ADDR) || (next_state == ST_LATCH);
    wire s_data_phase = s_active || (next_state == ST_RELEASE);
    wire s_xfer = s_addr_phase || s_data_phase;

    always_comb begin
        next_pins.cs_n = !s_active;
        if (next_style) begin
            next_pins.rd_strobe_n = !s_active;
            next_pins.wr_rw = s_xfer ? !op_write : 1'b1;
        end else begin
            next_pins.rd_strobe_n = !(s_active && !op_write);
            next_pins.wr_rw = !(s_active && op_write);
        end
        next_pins.ale = !next_sep_addr && (next_state == ST_ADDR);
        next_pins.ad_oe = (!next_sep_addr && s_addr_phase) || (s_data_phase && op_write);
        next_pins.ad_o = s_addr_phase ? {1'b0, op_addr} : op_data;
        next_pins.addr = op_addr;
    end

    phrp_timer u_timer (
        .clk(clk),
        .srst(srst),
        .load(enter_strobe || enter_release),
        .count(enter_strobe ? RDY_TIMEOUT_CYC : (op_write ? WR_GAP_CYC : GAP_CYC)),
        .remaining(remaining),
        .done(t_done)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            cur <= '0;
            unlock_phase <= 1'b0;
            pins <= '{cs_n: 1'b1, rd_strobe_n: 1'b1, wr_rw: 1'b1, ale: 1'b0, ad_o: 8'h00, ad_oe: 1'b0, addr: 7'h00};
            cmd_ready <= 1'b0;
            bus_style_select <= 1'b0;
            address_mux_select <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            unlock_phase <= next_unlock;
            pins <= next_pins;
            cmd_ready <= (next_state == ST_IDLE);
            bus_style_select <= next_style;
            address_mux_select <= next_sep_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_timeout <= 1'b0;
        end else begin
            rsp_valid <= strobe_end && !unlock_phase;
            // Timeout of the hidden unlock cycle is not reported on its own
            rsp_timeout <= strobe_end && !rdy_ok && !unlock_phase;
            if (strobe_end && !cur.write) begin
                rsp_rdata <= ad_s2;
            end
        end
    end

    // Helper: the last strobe belonged to a write
    logic last_wr;
    always_ff @(posedge clk) begin
        if (srst) begin
            last_wr <= 1'b0;
        end else if (!pins.cs_n) begin
            last_wr <= bus_style_select ? !pins.wr_rw : !pins.wr_rw;
        end
    end

    sequence s_unlock_cycle;
        !pins.cs_n && pins.ad_oe && (pins.ad_o == UNLOCK_VAL);
    endsequence

    property p_unlock_first;
        @(posedge clk) disable iff (srst)
        (fire && cmd.write && cmd.protect) |-> ##[2:4] s_unlock_cycle;
    endproperty
    a_unlock_first: assert property (p_unlock_first) else $error("protected write without unlock");

    property p_strobe_active;
        @(posedge clk) disable iff (srst)
        $fell(pins.cs_n) |=> !pins.cs_n [*3];
    endproperty
    a_strobe_active: assert property (p_strobe_active) else $error("strobe active too short");

    property p_strobe_inactive;
        @(posedge clk) disable iff (srst)
        $rose(pins.cs_n) |=> pins.cs_n;
    endproperty
    a_strobe_inactive: assert property (p_strobe_inactive) else $error("strobe inactive too short");

    property p_wr_spacing;
        @(posedge clk) disable iff (srst)
        ($rose(pins.cs_n) && last_wr) |-> pins.cs_n [*4];
    endproperty
    a_wr_spacing: assert property (p_wr_spacing) else $error("write strobes too close");

    property p_readback;
        @(posedge clk) disable iff (srst)
        ($rose(pins.cs_n) && last_wr) |-> pins.rd_strobe_n [*4];
    endproperty
    a_readback: assert property (p_readback) else $error("readback too soon after write");

    // Write strobe falls together with chip select, so stability counts from the next cycle
    property p_pair_strobes;
        @(posedge clk) disable iff (srst)
        (!pins.cs_n && !bus_style_select) |->
            (pins.rd_strobe_n != pins.wr_rw) && ($fell(pins.cs_n) || $stable(pins.wr_rw));
    endproperty
    a_pair_strobes: assert property (p_pair_strobes) else $error("strobe pair misuse");

    property p_rw_dir;
        @(posedge clk) disable iff (srst)
        (!pins.cs_n && bus_style_select) |-> !pins.rd_strobe_n && (pins.wr_rw == !(unlock_phase || cur.write));
    endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("direction line wrong");

    property p_addr_latch;
        @(posedge clk) disable iff (srst)
        $fell(pins.ale) |-> pins.ad_oe && (pins.ad_o[6:0] == (unlock_phase ? WP_REG_ADDR : cur.addr))
            ##1 !pins.cs_n;
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not held at latch");
endmodule // phrp_host

// ### phrp_dev_model.sv
// Behavioural device behind the parallel register port
`timescale 1ns/100ps
module phrp_dev_model
    import phrp_pkg::*;
#(
    parameter logic [6:0] PROT_BASE = 7'h60
) (
    input wire logic clk,
    input wire logic bus_style_select,
    input wire logic address_mux_select,
    input wire phrp_pins_t pins,
    input wire logic [7:0] ad_bus,
    input wire logic [3:0] rdy_dly,
    output logic [7:0] dev_ad,
    output logic dev_oe,
    output logic rdy
);
    logic [7:0] mem [0:127];
    logic [6:0] lat_addr = 7'h00;
    logic unlocked = 1'b0;
    logic [3:0] cnt = 4'h0;
    wire logic [6:0] addr = address_mux_select ? pins.addr : lat_addr;
    wire logic rd_act = !pins.cs_n && !pins.rd_strobe_n && (pins.wr_rw || !bus_style_select);
    wire logic wr_act = !pins.cs_n && (bus_style_select ? !pins.rd_strobe_n && !pins.wr_rw : !pins.wr_rw);
    initial for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    always @(negedge pins.ale) if (!address_mux_select) lat_addr <= ad_bus[6:0];
    // Write lands when the strobe ends; unlock is spent by one write
    always @(negedge wr_act) begin
        if (addr == WP_REG_ADDR) begin
            unlocked <= (ad_bus == UNLOCK_VAL);
        end else begin
            if (addr < PROT_BASE || unlocked) mem[addr] <= ad_bus;
            unlocked <= 1'b0;
        end
    end
    assign dev_oe = rd_act;
    assign dev_ad = mem[addr];
    always @(posedge clk) cnt <= (rd_act || wr_act) ? cnt + 4'(cnt != 4'hf) : 4'h0;
    // Pull-down: low whenever no access is under way
    assign rdy = (rd_act || wr_act) && cnt >= rdy_dly;
endmodule // phrp_dev_model

// ### parallel_host_register_port_tb_top.sv
// Self-checking testbench for the host register port controller
`timescale 1ns/100ps
module parallel_host_register_port_tb_top;
    import phrp_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cfg_bus_style = 1'b0;
    logic cfg_addr_mux = 1'b0;
    logic cmd_valid = 1'b0;
    phrp_cmd_t cmd = '0;
    logic [3:0] rdy_dly = 4'h1;
    logic cmd_ready, rsp_valid, rsp_timeout, bus_style_select, address_mux_select, dev_oe, rdy, to;
    logic [7:0] rsp_rdata, dev_ad, rd;
    logic [7:0] ad_last = 8'h00;
    phrp_pins_t pins;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    time t_fall = 0;
    time t_rise = 0;
    time t_wr = 0;
    // Released bus shows the inverse of its last level
    wire logic [7:0] ad_bus = pins.ad_oe ? pins.ad_o : (dev_oe ? dev_ad : ~ad_last);
    phrp_host u_phrp_host (.clk(clk), .srst(srst), .cfg_bus_style(cfg_bus_style), .cfg_addr_mux(cfg_addr_mux),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_timeout(rsp_timeout), .bus_style_select(bus_style_select), .address_mux_select(address_mux_select),
        .pins(pins), .ad_i(ad_bus), .rdy_i(rdy));
    phrp_dev_model u_phrp_dev_model (.clk(clk), .bus_style_select(bus_style_select),
        .address_mux_select(address_mux_select), .pins(pins), .ad_bus(ad_bus), .rdy_dly(rdy_dly),
        .dev_ad(dev_ad), .dev_oe(dev_oe), .rdy(rdy));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (pins.ad_oe || dev_oe) ad_last <= ad_bus;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge pins.cs_n) begin
        check({7'h00, ($time - t_rise) >= T_STROBE_INACT_NS}, 8'h01);
        t_fall = $time;
    end
    always @(posedge pins.cs_n) begin
        if (!srst) check({7'h00, ($time - t_fall) >= T_STROBE_ACT_NS}, 8'h01);
        t_rise = $time;
    end
    // Unknown-to-low at the first reset edge is no write
    always @(negedge u_phrp_dev_model.wr_act) begin
        if (!srst) check({7'h00, ($time - t_wr) >= T_WR_SPACE_NS}, 8'h01);
        t_wr = $time;
    end
    task access(input logic w, input logic p, input logic [6:0] a, input logic [7:0] d);
        int k;
        cmd = '{write: w, protect: p, addr: a, wdata: d};
        cmd_valid = 1'b1;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        check({7'h00, rsp_valid}, 8'h01);
        rd = rsp_rdata;
        to = rsp_timeout;
    endtask
    // Every strobe style and address mode, readback right after the write
    task t_modes;
        for (int m = 0; m < 4; m++) begin
            cfg_bus_style = m[0];
            cfg_addr_mux = m[1];
            access(1'b1, 1'b0, 7'(m * 21 + 1), 8'(8'ha0 + m));
            check({7'h00, bus_style_select}, {7'h00, m[0]});
            check({7'h00, address_mux_select}, {7'h00, m[1]});
            access(1'b0, 1'b0, 7'(m * 21 + 1), 8'h00);
            check(rd, 8'(8'ha0 + m));
        end
        for (int m = 0; m < 4; m++) begin
            cfg_bus_style = m[1];
            cfg_addr_mux = m[0];
            access(1'b0, 1'b0, 7'(m * 21 + 1), 8'h00);
            check(rd, 8'(8'ha0 + m));
        end
    endtask
    // Top address is protected in the model
    task t_protect;
        access(1'b1, 1'b0, 7'h7f, 8'h5a);
        access(1'b0, 1'b0, 7'h7f, 8'h00);
        check(rd, 8'h00);
        access(1'b1, 1'b1, 7'h7f, 8'h5a);
        access(1'b0, 1'b0, 7'h7f, 8'h00);
        check(rd, 8'h5a);
        access(1'b1, 1'b0, 7'h7f, 8'h11);
        access(1'b0, 1'b0, 7'h7f, 8'h00);
        check(rd, 8'h5a);
    endtask
    // Ready too late must end the access flagged
    task t_ready;
        rdy_dly = 4'h9;
        access(1'b0, 1'b0, 7'h01, 8'h00);
        check({7'h00, to}, 8'h01);
        rdy_dly = 4'h0;
        access(1'b0, 1'b0, 7'h01, 8'h00);
        check({7'h00, to}, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1;
        srst = 1'b0;
        t_modes();
        t_protect();
        t_ready();
        conclude();
    end
endmodule // parallel_host_register_port_tb_top
